/* File: sim/board_side_model.sv */
// Board model: free-running clock sources and strap resistors.
// Assumes the device's strap drive overrides the resistors while enabled.
`timescale 1ns/1ps
`default_nettype none
module board_side_model (
   // Clock
   input wire logic sys_clk,
   // Board strap setting and device drive
   input wire logic [3:0] strap_val,
   input wire logic [3:0] strap_out,
   input wire logic strap_oe,
   // Pins
   output logic primary_clock_in,
   output logic bus_clock_in,
   output logic [2:0] reset_source_strap_in,
   output logic primary_clock_divide_strap,
   output logic input_clock_divide_strap
);
   // ==========================================================
   // Clocks: primary period 4 cycles, bus period 6 cycles
   logic [3:0] ph = 4'h0;
   always @(posedge sys_clk) ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
   assign primary_clock_in = ph[1];
   assign bus_clock_in = (ph < 4'h3) || (ph > 4'h5 && ph < 4'h9);
   // ==========================================================
   // straps, driven pins win
   assign reset_source_strap_in = strap_oe ? strap_out[2:0] : strap_val[2:0];
   assign primary_clock_divide_strap = strap_oe ? strap_out[3] : strap_val[3];
   assign input_clock_divide_strap = strap_oe ? strap_out[3] : ~strap_val[3];
endmodule
`default_nettype wire

/* File: sim/reset_init_sequencer_properties.sv */
// Concurrent checks on the reset sequencer's top-level ports.
// Assumes one sys_clk domain with rst_n as asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "reset_init_consts.vh"
module reset_init_sequencer_properties (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Observed outputs
   input wire logic hard_reset_n,
   input wire logic soft_reset_n,
   input wire logic hard_reset_oe,
   input wire logic soft_reset_oe,
   input wire logic [`STRAP_W-1:0] strap_out,
   input wire logic strap_oe,
   input wire logic [`SRC_SEL_W-1:0] reset_source,
   input wire logic clock_divide,
   input wire logic clocks_ready,
   input wire logic sync_tick
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Sync ticks seen while hard reset is driven
   logic [9:0] low_ticks;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) low_ticks <= 10'h0;
      else if (hard_reset_n) low_ticks <= 10'h0;
      else if (sync_tick && low_ticks != 10'h3ff) low_ticks <= low_ticks + 10'h1;
   end
   // Sync ticks seen while soft reset is driven
   logic [9:0] soft_low_ticks;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) soft_low_ticks <= 10'h0;
      else if (soft_reset_n) soft_low_ticks <= 10'h0;
      else if (sync_tick && soft_low_ticks != 10'h3ff) soft_low_ticks <= soft_low_ticks + 10'h1;
   end
   // ==========================================================
   // Assertions
   a_hard_oe_match: assert property (hard_reset_oe == !hard_reset_n) else $error("hard oe wrong");
   a_soft_oe_match: assert property (soft_reset_oe == !soft_reset_n) else $error("soft oe wrong");
   a_hard_min_hold: assert property ($rose(hard_reset_n) |-> low_ticks >= 10'd511)
      else $error("hard reset released early");
   a_soft_min_hold: assert property ($rose(soft_reset_n) |-> soft_low_ticks >= 10'd511)
      else $error("soft reset released early");
   a_soft_after_hard: assert property ($rose(soft_reset_n) |-> $past(hard_reset_n, 16))
      else $error("soft released too soon");
   a_strap_off_reset: assert property (!hard_reset_n |-> !strap_oe) else $error("straps driven in reset");
   a_strap_on_later: assert property ($rose(strap_oe) |-> $past(hard_reset_n, 2))
      else $error("straps driven too soon");
   a_strap_drive_value: assert property (strap_oe |-> strap_out == {clock_divide, reset_source})
      else $error("strap drive value wrong");
   a_ready_after_release: assert property ($rose(clocks_ready) |-> hard_reset_n && soft_reset_n)
      else $error("clocks ready in reset");
   a_tick_single_pulse: assert property (sync_tick |=> !sync_tick) else $error("tick too long");
endmodule
bind reset_init_sequencer reset_init_sequencer_properties chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n), .hard_reset_oe(hard_reset_oe),
   .soft_reset_oe(soft_reset_oe), .strap_out(strap_out), .strap_oe(strap_oe), .reset_source(reset_source),
   .clock_divide(clock_divide), .clocks_ready(clocks_ready), .sync_tick(sync_tick));
`default_nettype wire

/* File: sim/reset_init_sequencer_tb_top.sv */
// Self-checking bench for the reset initialization sequencer.
// Assumes a 10 MHz sys_clk and the board model on the pin side.
`timescale 1ns/1ps
`default_nettype none
module reset_init_sequencer_tb_top;
   logic sys_clk = 1'b0, rst_n = 1'b0, host_mode = 1'b1, pll_locked = 1'b0;
   logic por_n = 1'b0, hard_in_n = 1'b1, soft_in_n = 1'b1;
   logic [3:0] strap_val = 4'h0, strap_out;
   logic prim, bus, div_p, div_i, hard_reset_n, soft_reset_n, strap_oe, clock_divide, clocks_ready, sync_tick;
   logic [2:0] src_pins, reset_source;
   int error_cnt = 0, samples_checked = 0, tick_cnt = 0, cyc = 0, t_soft = 0;
   string nm_q[$];
   logic [15:0] exp_q[$], got_q[$];
   initial forever #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;
   always @(posedge sys_clk) if (sync_tick === 1'b1) tick_cnt <= tick_cnt + 1;
   board_side_model board (.sys_clk(sys_clk), .strap_val(strap_val), .strap_out(strap_out), .strap_oe(strap_oe),
      .primary_clock_in(prim), .bus_clock_in(bus), .reset_source_strap_in(src_pins),
      .primary_clock_divide_strap(div_p), .input_clock_divide_strap(div_i));
   reset_init_sequencer uut (.sys_clk(sys_clk), .rst_n(rst_n), .host_mode(host_mode), .primary_clock_in(prim),
      .bus_clock_in(bus), .pll_locked(pll_locked), .power_on_reset_n(por_n), .hard_reset_in_n(hard_in_n),
      .soft_reset_in_n(soft_in_n), .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n),
      .hard_reset_oe(), .soft_reset_oe(), .reset_source_strap_in(src_pins), .primary_clock_divide_strap(div_p),
      .input_clock_divide_strap(div_i), .strap_out(strap_out), .strap_oe(strap_oe), .reset_source(reset_source),
      .clock_divide(clock_divide), .clocks_ready(clocks_ready), .sync_tick(sync_tick));
   // ==========================================================
   // Expected notes and the watching process
   task note(input string n, input logic [15:0] e, input logic [15:0] g);
      nm_q.push_back(n);
      exp_q.push_back(e);
      got_q.push_back(g);
   endtask
   task compare_val(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   always @(negedge sys_clk) while (got_q.size() > 0) compare_val(nm_q.pop_front(), exp_q.pop_front(), got_q.pop_front());
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================================
   // Stimulus helpers
   task automatic wait_sig(input int w, input logic v, input string n);
      logic s;
      for (int i = 0; i < 20000; i++) begin
         @(posedge sys_clk);
         #1;
         s = (w == 0) ? hard_reset_n : (w == 1) ? soft_reset_n : clocks_ready;
         if (s === v) break;
      end
      // Return on a rising edge so the caller drives on it
      @(posedge sys_clk);
      note(n, v, s);
   endtask
   task automatic pulse_req(input logic hard, input int n);
      if (hard) hard_in_n <= 1'b0;
      else soft_in_n <= 1'b0;
      repeat (n) @(posedge sys_clk iff sync_tick);
      hard_in_n <= 1'b1;
      soft_in_n <= 1'b1;
   endtask
   task automatic power_up(input logic host, input logic d);
      int t0;
      logic [3:0] s;
      s = {d, 3'($urandom)};
      @(posedge sys_clk);
      host_mode <= host;
      por_n <= 1'b0;
      pll_locked <= 1'b0;
      strap_val <= s;
      // long hold with straps set early
      repeat (300) @(posedge sys_clk);
      por_n <= 1'b1;
      t0 = tick_cnt;
      wait_sig(0, 1'b1, "hard_reset_n");
      note("hard_ticks", 1, tick_cnt - t0 >= 512);
      t0 = tick_cnt;
      pll_locked <= 1'b1;
      wait_sig(1, 1'b1, "soft_reset_n");
      note("soft_ticks", 1, tick_cnt - t0 >= 16);
      note("straps", {host ? s[3] : ~s[3], s[2:0]}, {clock_divide, reset_source});
      note("strap_oe", 1, strap_oe);
      wait_sig(2, 1'b1, "clocks_ready");
      @(posedge sys_clk iff sync_tick);
      t0 = cyc;
      @(posedge sys_clk iff sync_tick);
      note("tick_gap", host ? (d ? 16 : 8) : 6, cyc - t0);
      strap_val <= ~s;
      repeat (20) @(posedge sys_clk);
      note("held_straps", {host ? s[3] : ~s[3], s[2:0]}, {clock_divide, reset_source});
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (80000) @(posedge sys_clk);
      error_cnt++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(97));
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         power_up(i < 2, i[0]);
         $display("power-up test %0d done", i);
      end
      pulse_req(1'b0, 20);
      repeat (60) @(posedge sys_clk);
      note("short_soft", 1, soft_reset_n);
      t_soft = tick_cnt;
      pulse_req(1'b0, 36);
      wait_sig(1, 1'b0, "soft_request");
      note("hard_kept", 1, hard_reset_n);
      wait_sig(1, 1'b1, "soft_back");
      note("soft_only_ticks", 1, tick_cnt - t_soft >= 32 + 512);
      $display("soft request test done");
      pulse_req(1'b1, 36);
      wait_sig(0, 1'b0, "hard_request");
      note("strap_off", 0, strap_oe);
      wait_sig(0, 1'b1, "hard_rerun");
      wait_sig(1, 1'b1, "soft_rerun");
      $display("hard request test done");
      @(negedge sys_clk);
      @(negedge sys_clk);
      tally_and_finish;
   end
endmodule
`default_nettype wire

/* File: verilog/reset_init_consts.vh */
// Constants for the reset initialization sequencer.
// Assumes a 10 MHz sys_clk; all counts are in sys_clk cycles, sync ticks or primary clock periods.
`ifndef RESET_INIT_CONSTS_VH
`define RESET_INIT_CONSTS_VH

// Clock rate in kHz and lock time in microseconds
`define SYS_CLK_KHZ 10000
`define PLL_LOCK_US 100
// Lock wait in sys_clk cycles: 100 us at 10 MHz
`define PLL_LOCK_CYCLES 1000

// Counts in bus synchronisation clock periods; IN_ASSERT_MIN also counts power-on low time in primary clock periods
`define IN_ASSERT_MIN 32
`define OUT_ASSERT_MIN 512
`define SOFT_AFTER_HARD 16
`define STRAP_DRIVE_DELAY 1

// Strap field layout
`define SRC_SEL_W 3
`define STRAP_W 4
`define STRAP_DIV_BIT 3

// Sync divider ratios (primary clock periods per sync tick)
`define DIV_RATIO_LO 2
`define DIV_RATIO_HI 4

`endif

/* File: verilog/reset_init_sequencer.v */
// Reset initialization sequencer: clock select, reset qualification, reset
// outputs, strap capture and strap pin drive, PLL lock wait.
// Assumes reset and strap pins are asynchronous; clocks are sampled as levels.
// Function
// - Host uses primary clock, agent bus clock
// - Hard/soft inputs need 32 sync periods low, power-on 32 primary periods
// - Reset outputs held at least 512 periods
// - Soft released 16 periods after hard
// - Straps undriven in hard reset, driven later
// - Straps: 3-bit source, 1 divider bit
// - Host sync period follows divider strap
// - Wait 100 us for PLL lock
`timescale 1ns/1ps
`default_nettype none
`include "reset_init_consts.vh"
module reset_init_sequencer (
   // Clock and reset
   input wire sys_clk,
   input wire rst_n,
   // Mode and clock pins
   input wire host_mode,
   input wire primary_clock_in,
   input wire bus_clock_in,
   input wire pll_locked,
   // Reset pins
   input wire power_on_reset_n,
   input wire hard_reset_in_n,
   input wire soft_reset_in_n,
   output reg hard_reset_n,
   output reg soft_reset_n,
   output wire hard_reset_oe,
   output wire soft_reset_oe,
   // Strap pins
   input wire [`SRC_SEL_W-1:0] reset_source_strap_in,
   input wire primary_clock_divide_strap,
   input wire input_clock_divide_strap,
   output reg [`STRAP_W-1:0] strap_out,
   output reg strap_oe,
   // Status
   output reg [`SRC_SEL_W-1:0] reset_source,
   output reg clock_divide,
   output reg clocks_ready,
   output wire sync_tick
);
   localparam ST_POR = 3'h0;
   localparam ST_HOLD = 3'h1;
   localparam ST_SOFT = 3'h2;
   localparam ST_LOCK = 3'h3;
   localparam ST_RUN = 3'h4;

   // =====================================================
   // Input synchronisers
   reg [6:0] sync_a;
   reg [6:0] sync_b;
   reg [4:0] strap_a;
   reg [4:0] strap_b;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         // Power-on input starts asserted, so leaving reset is no false release
         sync_a <= 7'h7b;
         sync_b <= 7'h7b;
         strap_a <= 5'h00;
         strap_b <= 5'h00;
      end else begin
         sync_a <= {pll_locked, host_mode, primary_clock_in, bus_clock_in,
                    power_on_reset_n, hard_reset_in_n, soft_reset_in_n};
         sync_b <= sync_a;
         strap_a <= {primary_clock_divide_strap, input_clock_divide_strap, reset_source_strap_in};
         strap_b <= strap_a;
      end
   end
   wire lock_s = sync_b[6];
   wire host_s = sync_b[5];
   wire por_s = sync_b[2];
   // Divider strap chosen by mode only after both are synchronised
   wire [`STRAP_W-1:0] strap_now = {(host_s ? strap_b[4] : strap_b[3]), strap_b[2:0]};

   // =====================================================
   // Primary clock select and edge detect
   reg clk_prev;
   wire clk_sel = host_s ? sync_b[4] : sync_b[3];
   wire prim_edge = clk_sel & ~clk_prev;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_prev <= 1'b1;
      end else begin
         clk_prev <= clk_sel;
      end
   end

   // =====================================================
   // Sync clock tick
   reg [2:0] div_cnt;
   wire [2:0] ratio = clock_divide ? 3'd`DIV_RATIO_HI : 3'd`DIV_RATIO_LO;
   wire host_tick = prim_edge && (div_cnt == ratio - 3'h1);
   assign sync_tick = host_s ? host_tick : prim_edge;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 3'h0;
      end else if (prim_edge) begin
         div_cnt <= host_tick ? 3'h0 : div_cnt + 3'h1;
      end
   end

   // =====================================================
   // Power-on reset length and strap capture
   reg [5:0] por_cnt;
   reg [2:0] setup_cnt;
   reg por_ok;
   reg por_prev;
   reg [`STRAP_W-1:0] strap_hold;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         por_cnt <= 6'h00;
         setup_cnt <= 3'h0;
         por_ok <= 1'b0;
         por_prev <= 1'b0;
         strap_hold <= {`STRAP_W{1'b0}};
         reset_source <= {`SRC_SEL_W{1'b0}};
         clock_divide <= 1'b0;
      end else begin
         por_prev <= por_s;
         if (!por_s) begin
            if (prim_edge && por_cnt < 6'd`IN_ASSERT_MIN) begin
               por_cnt <= por_cnt + 6'h01;
            end
            if (strap_now != strap_hold) begin
               strap_hold <= strap_now;
               setup_cnt <= 3'h0;
            end else if (prim_edge && setup_cnt < 3'h4) begin
               setup_cnt <= setup_cnt + 3'h1;
            end
         end else if (!por_prev) begin
            por_ok <= (por_cnt == 6'd`IN_ASSERT_MIN);
            reset_source <= strap_hold[`SRC_SEL_W-1:0];
            clock_divide <= strap_hold[`STRAP_DIV_BIT];
            por_cnt <= 6'h00;
         end
      end
   end

   // =====================================================
   // Reset input qualifiers
   wire hard_q;
   wire soft_q;
   reset_input_qualifier u_hard_q (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .level_n(sync_b[1]),
      .tick(sync_tick),
      .qualified(hard_q)
   );
   reset_input_qualifier u_soft_q (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .level_n(sync_b[0]),
      .tick(sync_tick),
      .qualified(soft_q)
   );

   // =====================================================
   // Reset sequence
   reg [2:0] state;
   reg [9:0] tcount;
   reg [10:0] lock_cnt;
   reg [1:0] drive_cnt;
   reg soft_only;
   wire restart = hard_q && (state == ST_SOFT || state == ST_LOCK || state == ST_RUN);
   // Soft-only requests still hold the soft output for the full minimum
   wire [9:0] soft_last = soft_only ? 10'd`OUT_ASSERT_MIN - 10'h001 : 10'd`SOFT_AFTER_HARD - 10'h001;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_POR;
         tcount <= 10'h000;
         lock_cnt <= 11'h000;
         soft_only <= 1'b0;
         hard_reset_n <= 1'b0;
         soft_reset_n <= 1'b0;
         clocks_ready <= 1'b0;
      end else if (!por_s || restart) begin
         state <= ST_POR;
         soft_only <= 1'b0;
         hard_reset_n <= 1'b0;
         soft_reset_n <= 1'b0;
         clocks_ready <= 1'b0;
      end else begin
         case (state)
            ST_POR: begin
               tcount <= 10'h000;
               state <= ST_HOLD;
            end
            ST_HOLD: begin
               hard_reset_n <= 1'b0;
               soft_reset_n <= 1'b0;
               if (sync_tick) begin
                  if (tcount == 10'd`OUT_ASSERT_MIN - 10'h001) begin
                     hard_reset_n <= 1'b1;
                     tcount <= 10'h000;
                     state <= ST_SOFT;
                  end else begin
                     tcount <= tcount + 10'h001;
                  end
               end
            end
            ST_SOFT: begin
               if (sync_tick) begin
                  if (tcount == soft_last) begin
                     soft_reset_n <= 1'b1;
                     soft_only <= 1'b0;
                     lock_cnt <= 11'h000;
                     state <= ST_LOCK;
                  end else begin
                     tcount <= tcount + 10'h001;
                  end
               end
            end
            ST_LOCK: begin
               if (lock_s || lock_cnt == 11'd`PLL_LOCK_CYCLES - 11'h001) begin
                  clocks_ready <= por_ok;
                  state <= ST_RUN;
               end else begin
                  lock_cnt <= lock_cnt + 11'h001;
               end
            end
            ST_RUN: begin
               if (soft_q) begin
                  soft_reset_n <= 1'b0;
                  soft_only <= 1'b1;
                  tcount <= 10'h000;
                  state <= ST_SOFT;
               end
            end
            default: state <= ST_POR;
         endcase
      end
   end
   assign hard_reset_oe = ~hard_reset_n;
   assign soft_reset_oe = ~soft_reset_n;

   // =====================================================
   // Strap pin drive
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_cnt <= 2'h0;
         strap_oe <= 1'b0;
         strap_out <= {`STRAP_W{1'b0}};
      end else begin
         strap_out <= {clock_divide, reset_source};
         // off in hard reset, on later
         // Cleared on the same edge that asserts hard reset
         if (!hard_reset_n || !por_s || restart) begin
            drive_cnt <= 2'h0;
            strap_oe <= 1'b0;
         end else if (sync_tick && drive_cnt < 2'd`STRAP_DRIVE_DELAY) begin
            drive_cnt <= drive_cnt + 2'h1;
         end else if (drive_cnt == 2'd`STRAP_DRIVE_DELAY) begin
            strap_oe <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/reset_input_qualifier.v */
// Qualifier for one active-low reset input.
// Assumes the input is already synchronised and tick is a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module reset_input_qualifier (
   // Clock and reset
   input wire sys_clk,
   input wire rst_n,
   // Sampled input and count enable
   input wire level_n,
   input wire tick,
   // Pulse when the input has been low long enough
   output reg qualified
);
   reg [5:0] count;

   // =====================================================
   // Low-time counter
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 6'h00;
         qualified <= 1'b0;
      end else begin
         qualified <= 1'b0;
         if (level_n) begin
            count <= 6'h00;
         end else if (tick && count < 6'd`IN_ASSERT_MIN) begin
            count <= count + 6'h01;
            if (count == 6'd`IN_ASSERT_MIN - 6'h01) begin
               qualified <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire
